//--- bscr_defs.svh
// Register offsets, field positions, reset values and the clock frequency for the board
// status and control register bank. Definitions only; included by bare name.
`ifndef BSCR_DEFS_SVH
`define BSCR_DEFS_SVH

`define BSCR_OFF_IDENT       3'h0
`define BSCR_OFF_JUMPER      3'h1
`define BSCR_OFF_SLOT        3'h2
`define BSCR_OFF_RESET       3'h3
`define BSCR_OFF_TEMP        3'h4
`define BSCR_OFF_MISC        3'h5

`define BSCR_RST_IN_EN_BIT   4
`define BSCR_LRST_EN_BIT     5
`define BSCR_RESV6_BIT       6
`define BSCR_OT_RELEASE_BIT  7
`define BSCR_LED_BIT         1
`define BSCR_TEMP_LOG_BIT    3
`define BSCR_TEMP_CRIT_BIT   7

`define BSCR_REV_ENGINEERING 4'hF
`define BSCR_REV_RECOVERY    4'h0

`define BSCR_CTRL_RESET      8'h00
`define BSCR_UNMAPPED_READ   8'h00

`define BSCR_CLK_HZ          10000000

`endif

//--- bscr_pkg.sv
// Types shared by the board status and control register bank.
// Assumes the constants header is included where offsets are needed.
package bscr_pkg;

   typedef logic [7:0] bscr_byte_t;

   typedef enum logic [1:0] {
      BSCR_OT_IDLE    = 2'h0,
      BSCR_OT_HOLD    = 2'h1,
      BSCR_OT_RELEASE = 2'h3
   } bscr_ot_e;

endpackage : bscr_pkg

//--- bscr_regs.sv
// Board status and control register bank: six byte-wide registers at 0x00..0x05.
// Assumes a single 10 MHz clock, a synchronous board reset and a separate
// synchronous backplane power-up reset; pin inputs may be asynchronous and pass a SYNC_STAGES synchroniser.
//
// Overview of operation
// - Identification low nibble returns logic revision.
// - Identification high nibble returns fixed family code.
// - Jumper bit 0 shows user jumper fitted.
// - Jumper bit 1 shows boot from firmware.
// - Jumper bit 2 shows flash write enabled.
// - Jumper bit 3 zero: shutdown forces reset.
// - Jumper bits 4-7 show segment speed straps.
// - Slot bits 0-5 show geographic address lines.
// - Slot bits 6 and 7 read zero.
// - Reset bits 0-3 are read-only status.
// - Backplane reset needs bit 4 and jumper.
// - Bit 5 gates bridge local reset output.
// - Bit 7 selects overtemp reset auto release.
// - Temperature bits 0-2 show live overtemp.
// - Temperature bit 3 logs overtemp until powercycle.
// - Temperature bits 4-6 show warning state.
// - Bit 7 sets critical, holds above warning.
// - Flash ready bits read one when idle.
// - Misc bit 1 drives LED, cleared on reset.
// - Misc bit 3 shows address bus joined.
// - Patch jumpers read zero fitted; spare one.
// - Registers accessed as single bytes by host.
`timescale 1ns/10ps
`include "bscr_defs.svh"

module bscr_regs #(
   parameter logic [3:0] REVISION    = 4'h1,
   parameter logic [3:0] FAMILY_CODE = 4'h9,  // Arbitrary value.
   parameter int         SYNC_STAGES = 2
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       bp_powerup_rst_n,
   // Host byte access port.
   input  wire logic       host_sel,
   input  wire logic       host_wr,
   input  wire logic [2:0] host_addr,
   input  wire logic [7:0] host_wdata,
   output logic      [7:0] host_rdata,
   output logic            host_ack,
   // Straps and jumpers, high when fitted unless noted.
   input  wire logic       user_jumper,
   input  wire logic       boot_select_jumper,
   input  wire logic       flash_write_enable_jumper,
   input  wire logic       shutdown_override_jumper,
   input  wire logic [3:0] local_bus_seg_66en,
   input  wire logic [5:0] geo_addr_grounded,
   input  wire logic       system_controller_jumper,
   input  wire logic       reset_out_jumper,
   input  wire logic       reset_in_jumper,
   input  wire logic       bridge_is_sys_ctrl,
   input  wire logic [2:0] overtemp_sense,
   input  wire logic [2:0] warning_sense,
   input  wire logic       boot_firmware_flash_ready,
   input  wire logic       user_flash_ready,
   input  wire logic       mux_select_jumper,
   input  wire logic [2:0] patch_jumper_fitted,
   input  wire logic       spare_jumper,
   input  wire logic       backplane_reset_in,
   input  wire logic       bridge_local_reset,
   output logic            board_reset_req,
   output logic            overtemp_reset,
   output logic            muxed_address_joined,
   output logic            system_led
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   localparam int NIN = 33;

   if (SYNC_STAGES < 2) begin : g_bad_sync_stages
      $error("SYNC_STAGES must be at least 2.");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   // The power-cycle domain (log bit, reset routing) is kept apart from the
   // board reset so that a front-panel reset leaves it untouched.
   typedef struct packed {
      logic [SYNC_STAGES*NIN-1:0] sync;
      bscr_pkg::bscr_byte_t       rdata;
      logic                       ack;
      logic                       led;
      logic                       crit;
      bscr_pkg::bscr_ot_e         ot;
      logic                       board_rst;
      logic                       ot_rst;
      logic                       mux_joined;
   } bscr_board_s;

   typedef struct packed {
      logic rst_in_en;
      logic lrst_en;
      logic resv6;
      logic ot_release;
      logic temp_log;
   } bscr_power_s;

   bscr_board_s r;
   bscr_board_s next_r;
   bscr_power_s p;
   bscr_power_s next_p;

   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] s;
   logic [7:0]     reg_jumper;
   logic [7:0]     reg_slot;
   logic [7:0]     reg_reset;
   logic [7:0]     reg_temp;
   logic [7:0]     reg_misc;
   logic           wr_reset;

   // ---------------------------------------------------------------
   // Input synchroniser
   // ---------------------------------------------------------------
   assign raw_in = {backplane_reset_in, bridge_local_reset, spare_jumper,
                    patch_jumper_fitted, mux_select_jumper, user_flash_ready,
                    boot_firmware_flash_ready, warning_sense, overtemp_sense,
                    bridge_is_sys_ctrl, reset_in_jumper, reset_out_jumper,
                    system_controller_jumper, geo_addr_grounded,
                    local_bus_seg_66en, shutdown_override_jumper,
                    flash_write_enable_jumper, boot_select_jumper, user_jumper};

   // Only the last stage is ever looked at.
   assign s = r.sync[SYNC_STAGES*NIN-1 -: NIN];

   // ---------------------------------------------------------------
   // Read views
   // ---------------------------------------------------------------
   assign reg_jumper = {s[7:4], s[3], s[2], s[1], s[0]};
   assign reg_slot   = {2'h0, s[13:8]};
   assign reg_reset  = {p.ot_release, p.resv6, p.lrst_en, p.rst_in_en,
                        s[17], s[16], s[15], s[14]};
   assign reg_temp   = {r.crit, s[23:21], p.temp_log, s[20:18]};
   assign reg_misc   = {s[30], ~s[29:27], s[26] ? 1'b0 : 1'b1, s[25],
                        r.led, s[24]};

   assign wr_reset = host_sel && host_wr && (host_addr == `BSCR_OFF_RESET);

   // ---------------------------------------------------------------
   // Board-reset domain
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.sync = {r.sync[SYNC_STAGES*NIN-NIN-1:0], raw_in};
      next_r.ack  = host_sel;
      if (host_sel && !host_wr) begin
         case (host_addr)
            `BSCR_OFF_IDENT:  next_r.rdata = {FAMILY_CODE, REVISION};
            `BSCR_OFF_JUMPER: next_r.rdata = reg_jumper;
            `BSCR_OFF_SLOT:   next_r.rdata = reg_slot;
            `BSCR_OFF_RESET:  next_r.rdata = reg_reset;
            `BSCR_OFF_TEMP:   next_r.rdata = reg_temp;
            `BSCR_OFF_MISC:   next_r.rdata = reg_misc;
            default:          next_r.rdata = `BSCR_UNMAPPED_READ;
         endcase
      end
      if (host_sel && host_wr && host_addr == `BSCR_OFF_MISC) begin
         next_r.led = host_wdata[`BSCR_LED_BIT];
      end
      // Critical flag: set on any live overtemp, held while any warning stands.
      if (|s[20:18]) begin
         next_r.crit = 1'b1;
      end else if (~|s[23:21]) begin
         next_r.crit = 1'b0;
      end
      // Overtemp reset: hold, or release after the condition clears.
      case (r.ot)
         bscr_pkg::BSCR_OT_IDLE: begin
            if (|s[20:18]) begin
               next_r.ot = bscr_pkg::BSCR_OT_HOLD;
            end
         end
         bscr_pkg::BSCR_OT_HOLD: begin
            if (p.ot_release && ~|s[20:18]) begin
               next_r.ot = bscr_pkg::BSCR_OT_RELEASE;
            end
         end
         bscr_pkg::BSCR_OT_RELEASE: begin
            next_r.ot = bscr_pkg::BSCR_OT_IDLE;
         end
         default: begin
            next_r.ot = bscr_pkg::BSCR_OT_IDLE;
         end
      endcase
      next_r.ot_rst = (next_r.ot == bscr_pkg::BSCR_OT_HOLD);
      // Reset routing; a shutdown reset is suppressed by the override jumper.
      next_r.board_rst = (s[32] && p.rst_in_en && s[16])
                       || (s[31] && p.lrst_en)
                       || (next_r.ot_rst && !s[3]);
      next_r.mux_joined = s[26] ? 1'b0 : 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // Power-cycle domain
   // ---------------------------------------------------------------
   // Power-up reset wins over set: the log only clears on backplane power-up.
   always_comb begin
      next_p = p;
      if (wr_reset) begin
         next_p.rst_in_en  = host_wdata[`BSCR_RST_IN_EN_BIT];
         next_p.lrst_en    = host_wdata[`BSCR_LRST_EN_BIT];
         next_p.resv6      = host_wdata[`BSCR_RESV6_BIT];
         next_p.ot_release = host_wdata[`BSCR_OT_RELEASE_BIT];
      end
      if (|s[20:18]) begin
         next_p.temp_log = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!bp_powerup_rst_n) begin
         p <= '0;
      end else begin
         p <= next_p;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign host_rdata           = r.rdata;
   assign host_ack             = r.ack;
   assign board_reset_req      = r.board_rst;
   assign overtemp_reset       = r.ot_rst;
   assign muxed_address_joined = r.mux_joined;
   assign system_led           = r.led;

endmodule : bscr_regs

//--- bscr_regs_chk.sv
// Checker for the board status and control register bank.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/10ps
module bscr_regs_chk (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       host_sel,
   input wire logic       host_wr,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   input wire logic       host_ack,
   input wire logic       mux_select_jumper,
   input wire logic [2:0] overtemp_sense,
   input wire logic       backplane_reset_in,
   input wire logic       bridge_local_reset,
   input wire logic       board_reset_req,
   input wire logic       overtemp_reset,
   input wire logic       muxed_address_joined,
   input wire logic       system_led
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_after_sel: assert property (host_sel |=> host_ack)
      else $error("ack missing after access");
   a_ack_no_stray: assert property (host_ack |-> $past(host_sel))
      else $error("ack without access");
   a_slot_top_zero: assert property (host_ack && $past(!host_wr && host_addr == 3'h2) |->
      host_rdata[7:6] == 2'h0) else $error("slot top bits not zero");
   a_unmapped_zero: assert property (host_ack && $past(!host_wr && host_addr[2:1] == 2'h3) |->
      host_rdata == 8'h00) else $error("unmapped read not zero");
   a_led_write: assert property (host_sel && host_wr && host_addr == 3'h5 |=>
      system_led == $past(host_wdata[1])) else $error("led not written");
   a_led_holds: assert property (!(host_sel && host_wr && host_addr == 3'h5) |=>
      $stable(system_led)) else $error("led changed without write");
   a_mux_follow: assert property ($stable(mux_select_jumper)[*5] |->
      muxed_address_joined == !mux_select_jumper) else $error("mux status wrong");
   a_quiet_no_reset: assert property ((!backplane_reset_in && !bridge_local_reset
      && !overtemp_reset)[*5] |-> !board_reset_req) else $error("reset without cause");
   a_ot_sets: assert property ((overtemp_sense != 3'h0)[*4] |-> ##[0:4] overtemp_reset)
      else $error("overtemp reset not raised");
   a_reset_clear: assert property ($rose(rst_n) |-> !system_led && !overtemp_reset)
      else $error("outputs not cleared by reset");
   c_write: cover property (host_sel && host_wr);
   c_ot: cover property (overtemp_reset);
   c_brd: cover property (board_reset_req);
endmodule : bscr_regs_chk

//--- bscr_host.sv
// Host processor model for the bank's byte port.
// Assumes the bank answers one cycle after each one-cycle strobe.
`timescale 1ns/10ps
module bscr_host (
   input  wire logic       clk,
   input  wire logic       host_ack,
   input  wire logic [7:0] host_rdata,
   output logic            host_sel,
   output logic            host_wr,
   output logic      [2:0] host_addr,
   output logic      [7:0] host_wdata
);
   initial begin
      host_sel = 1'b0;
      host_wr = 1'b0;
      host_addr = 3'h0;
      host_wdata = 8'h00;
   end
   // Released address and data lines show inverted values so a stale address can never pass.
   task acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      host_sel = 1'b1;
      host_wr = w;
      host_addr = a;
      host_wdata = d;
      @(negedge clk);
      host_sel = 1'b0;
      host_addr = ~a;
      host_wdata = ~d;
      q = (host_ack === 1'b1) ? host_rdata : 8'hXX;
   endtask : acc
endmodule : bscr_host

//--- tb_top.sv
// Bench for the register bank: host model, pin stimulus and checker bind.
// Assumes the bank, its checker and the host model are compiled first.
`timescale 1ns/10ps
module tb_top;
   localparam logic [3:0] REV = 4'hF;
   localparam logic [3:0] FAM = 4'h6;  // Arbitrary value.
   logic clk = 1'b0, rst_n, bp_powerup_rst_n, host_sel, host_wr, host_ack, spare_jumper;
   logic user_jumper, boot_select_jumper, flash_write_enable_jumper, shutdown_override_jumper;
   logic system_controller_jumper, reset_out_jumper, reset_in_jumper, bridge_is_sys_ctrl;
   logic boot_firmware_flash_ready, user_flash_ready, mux_select_jumper, system_led;
   logic backplane_reset_in, bridge_local_reset, board_reset_req, overtemp_reset;
   logic muxed_address_joined;
   logic [2:0] host_addr, overtemp_sense, warning_sense, patch_jumper_fitted;
   logic [7:0] host_wdata, host_rdata, q;
   logic [3:0] local_bus_seg_66en;
   logic [5:0] geo_addr_grounded;
   int fail_count = 0, samples_checked = 0;
   always #50 clk = ~clk;
   bscr_regs #(.REVISION(REV), .FAMILY_CODE(FAM)) dut (.*);
   bscr_host host (.clk, .host_ack, .host_rdata, .host_sel, .host_wr, .host_addr, .host_wdata);
   task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask : cmp
   task rd(input logic [2:0] a, input logic [7:0] e);
      host.acc(1'b0, a, 8'h00, q);
      cmp($sformatf("reg %0d", a), e, q);
   endtask : rd
   task wr(input logic [2:0] a, input logic [7:0] d);
      host.acc(1'b1, a, d, q);
   endtask : wr
   task pulse(input bit bp);
      @(negedge clk);
      if (bp) bp_powerup_rst_n = 1'b0;
      else rst_n = 1'b0;
      repeat (2) @(negedge clk);
      {rst_n, bp_powerup_rst_n} = 2'h3;
      // A board reset empties the synchroniser, so give it time to refill.
      settle;
   endtask : pulse
   // Straps pass two sync stages and a register before they can be read.
   task settle;
      repeat (4) @(negedge clk);
   endtask : settle
   task t_pins;
      logic [7:0] p;
      rd(3'h0, {FAM, REV});
      wr(3'h0, 8'h00);
      rd(3'h0, {FAM, REV});
      wr(3'h7, 8'hFF);
      rd(3'h6, 8'h00);
      rd(3'h7, 8'h00);
      for (int i = 0; i < 2; i++) begin
         p = i ? 8'h59 : 8'hA6;
         @(negedge clk);
         {local_bus_seg_66en, shutdown_override_jumper, flash_write_enable_jumper,
          boot_select_jumper, user_jumper} = p;
         geo_addr_grounded = p[5:0];
         settle;
         rd(3'h1, p);
         wr(3'h2, 8'hFF);
         rd(3'h2, {2'h0, p[5:0]});
      end
      $display("t_pins done");
   endtask : t_pins
   task t_rst;
      @(negedge clk);
      {bridge_is_sys_ctrl, reset_in_jumper, reset_out_jumper, system_controller_jumper} = 4'h5;
      settle;
      wr(3'h3, 8'hFF);
      rd(3'h3, 8'hF5);
      pulse(1'b0);
      rd(3'h3, 8'hF5);
      backplane_reset_in = 1'b1;
      settle;
      cmp("board_reset_req", 8'h01, {7'h0, board_reset_req});
      pulse(1'b1);
      rd(3'h3, 8'h05);
      cmp("board_reset_req", 8'h00, {7'h0, board_reset_req});
      {backplane_reset_in, bridge_local_reset} = 2'h1;
      settle;
      cmp("board_reset_req", 8'h00, {7'h0, board_reset_req});
      wr(3'h3, 8'h20);
      settle;
      cmp("board_reset_req", 8'h01, {7'h0, board_reset_req});
      bridge_local_reset = 1'b0;
      $display("t_rst done");
   endtask : t_rst
   task t_tmp;
      @(negedge clk);
      {overtemp_sense, warning_sense} = 6'h12;
      settle;
      rd(3'h4, 8'hAA);
      overtemp_sense = 3'h0;
      settle;
      rd(3'h4, 8'hA8);
      cmp("overtemp_reset", 8'h01, {7'h0, overtemp_reset});
      cmp("board_reset_req", 8'h00, {7'h0, board_reset_req});
      @(negedge clk);
      shutdown_override_jumper = 1'b0;
      settle;
      cmp("board_reset_req", 8'h01, {7'h0, board_reset_req});
      shutdown_override_jumper = 1'b1;
      warning_sense = 3'h0;
      pulse(1'b0);
      settle;
      rd(3'h4, 8'h08);
      wr(3'h3, 8'h80);
      overtemp_sense = 3'h4;
      settle;
      overtemp_sense = 3'h0;
      settle;
      cmp("overtemp_reset", 8'h00, {7'h0, overtemp_reset});
      pulse(1'b1);
      rd(3'h4, 8'h00);
      $display("t_tmp done");
   endtask : t_tmp
   task t_misc;
      @(negedge clk);
      {spare_jumper, patch_jumper_fitted, mux_select_jumper, user_flash_ready,
       boot_firmware_flash_ready} = 7'h6D;
      settle;
      rd(3'h5, 8'hA1);
      wr(3'h5, 8'hFF);
      rd(3'h5, 8'hA3);
      cmp("system_led", 8'h01, {7'h0, system_led});
      cmp("muxed_address_joined", 8'h00, {7'h0, muxed_address_joined});
      {spare_jumper, patch_jumper_fitted, mux_select_jumper, user_flash_ready,
       boot_firmware_flash_ready} = 7'h12;
      pulse(1'b0);
      settle;
      rd(3'h5, 8'h5C);
      cmp("muxed_address_joined", 8'h01, {7'h0, muxed_address_joined});
      $display("t_misc done");
   endtask : t_misc
   task print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   initial begin
      {rst_n, bp_powerup_rst_n, backplane_reset_in, bridge_local_reset, spare_jumper} = '0;
      {user_jumper, boot_select_jumper, flash_write_enable_jumper, shutdown_override_jumper} = '0;
      {system_controller_jumper, reset_out_jumper, reset_in_jumper, bridge_is_sys_ctrl} = '0;
      {boot_firmware_flash_ready, user_flash_ready, mux_select_jumper} = 3'h7;
      {overtemp_sense, warning_sense, patch_jumper_fitted} = '0;
      {local_bus_seg_66en, geo_addr_grounded} = '0;
      repeat (16) @(negedge clk);
      {rst_n, bp_powerup_rst_n} = 2'h3;
      t_pins;
      t_rst;
      t_tmp;
      t_misc;
      print_verdict;
   end
   initial begin
      #1000000;
      fail_count++;
      print_verdict;
   end
endmodule : tb_top
bind bscr_regs bscr_regs_chk chk (.clk, .rst_n, .host_sel, .host_wr, .host_addr, .host_wdata,
   .host_rdata, .host_ack, .mux_select_jumper, .overtemp_sense, .backplane_reset_in,
   .bridge_local_reset, .board_reset_req, .overtemp_reset, .muxed_address_joined, .system_led);
